//--- core/hcsr_pkg.sv
// Constants and carrier types of the host command and slave receive port
package hcsr_pkg;

    // Host memory offsets in host-bus interface mode
    localparam logic [15:0] OFS_STATUS = 16'h0014;
    localparam logic [15:0] OFS_CMD_VECTOR = 16'h0018;
    localparam logic [15:0] OFS_RX_FIRST = 16'h001C;
    localparam logic [15:0] OFS_RX_LAST = 16'hFFFC;

    // Universal bus low address line selects
    localparam logic [2:0] UB_SEL_STATUS = 3'h5;
    localparam logic [2:0] UB_SEL_CMD = 3'h6;
    localparam logic [2:0] UB_SEL_RX = 3'h7;

    // Interface mode encodings
    localparam logic [1:0] MODE_PCI = 2'h1;

    // Command vector register fields
    localparam int CV_PEND_BIT = 0;
    localparam int CV_VEC_LSB = 1;
    localparam int CV_NMI_BIT = 15;
    localparam logic [6:0] RST_VECTOR = 7'h00;

    // Status register fields
    localparam int ST_TRDY = 0;
    localparam int ST_TRQ = 1;
    localparam int ST_RRQ = 2;
    localparam int ST_FLAG_LSB = 3;
    localparam int ST_HOST_REQUEST_FLAG = 7;

    // PCI wait states before a retry termination
    localparam logic [3:0] MAX_WAITS = 4'h8;

    // Core interrupt level that beats every maskable level
    localparam logic [2:0] NMI_LEVEL = 3'h4;

    // Host access request
    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } hcsr_acc_t;

    // Host-side control settings
    typedef struct packed {
        logic [1:0] mode;
        logic target_wait_disable;
        logic [1:0] rx_fmt;
        logic [1:0] tx_fmt;
        logic rx_request_enable;
        logic tx_request_enable;
        logic dma_mode_enable;
        logic fetch_type_select;
        logic [7:0] base;
    } hcsr_cfg_t;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_GAP} hcsr_fsm_t;
    typedef enum logic [1:0] {K_NONE, K_STAT, K_CMD, K_RX} hcsr_kind_t;

endpackage

//--- core/hcsr_host_port.sv
// Host command vector, host status and slave receive output stage
`timescale 1ns/1ps
`default_nettype none
module hcsr_host_port
    import hcsr_pkg::*;
(
    // Core side clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Host bus clock
    input wire logic clk_link_i,
    // Host access, link domain
    input wire logic acc_req_i,
    input wire hcsr_acc_t acc_i,
    input wire hcsr_cfg_t cfg_i,
    input wire logic pers_hw_reset_i,
    input wire logic pers_sw_reset_i,
    input wire logic sw_reset_i,
    input wire logic tx_space_available_i,
    input wire logic tx_ready_i,
    input wire logic [6:0] cmd_default_vector_i,
    output logic acc_done_o,
    output logic acc_retry_o,
    output logic [31:0] acc_rdata_o,
    output logic host_request_flag_o,
    output logic host_irq_pin_o,
    output logic host_dma_request_pin_o,
    // Core side, system domain
    input wire logic [3:0] core_flags_i,
    input wire logic cmd_ack_i,
    input wire logic command_irq_enable_i,
    input wire logic [1:0] peripheral_priority_i,
    input wire logic core_rx_valid_i,
    input wire logic [31:0] core_rx_data_i,
    output logic core_rx_ready_o,
    output logic core_command_pending_o,
    output logic [6:0] cmd_vector_o,
    output logic cmd_nmi_o,
    output logic [7:0] cmd_start_addr_o,
    output logic cmd_irq_o,
    output logic [2:0] cmd_level_o
);

    ////////////////////////////////////////////////////////////////////
    // State types
    typedef struct packed {
        hcsr_fsm_t fsm;
        hcsr_kind_t kind;
        logic [3:0] wcnt;
        logic hc;
        logic [6:0] hv;
        logic nmi;
        logic [31:0] rx_data;
        logic rx_full;
        logic ack_s1, ack_s2, ack_prev;
        logic push_s1, push_s2, push_seen;
        logic [3:0] flg_s1, flg_s2;
        logic [31:0] rdata;
        logic done, retry, host_request_flag, irq, drq;
    } hcsr_link_t;

    typedef struct packed {
        logic hc_s1, hc_s2;
        logic pend, ack_wait, ack_tgl;
        logic [6:0] vec;
        logic nmi;
        logic push_tgl, busy;
        logic [31:0] push_data;
        logic seen_s1, seen_s2;
        logic irq;
        logic [2:0] level;
        logic rdy;
    } hcsr_sys_t;

    hcsr_link_t l_reg, l_next;
    hcsr_sys_t s_reg, s_next;
    logic ack_edge;
    logic is_pci, is_ub, sel_cmd, sel_rx, sel_st, blocked, go;
    logic ub16_cmd, ub16;
    logic [31:0] wd;

    // Rx stage through the format converter onto the data lanes
    function automatic logic [31:0] fmt_rx(input logic [31:0] d,
                                           input logic [1:0] f,
                                           input logic pci);
        case (f)
            2'h0: fmt_rx = {8'h00, d[23:0]};
            2'h1: fmt_rx = {16'h0000, d[15:0]};
            2'h2: fmt_rx = {16'h0000, d[31:16]};
            default: fmt_rx = pci ? d : {16'h0000, d[31:16]};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Link domain next state
    always_comb begin
        l_next = l_reg;
        l_next.done = 1'b0;
        l_next.retry = 1'b0;
        // Crossings from the core domain, two stages each
        l_next.ack_s1 = s_reg.ack_tgl;
        l_next.ack_s2 = l_reg.ack_s1;
        l_next.ack_prev = l_reg.ack_s2;
        l_next.push_s1 = s_reg.push_tgl;
        l_next.push_s2 = l_reg.push_s1;
        l_next.flg_s1 = core_flags_i;
        l_next.flg_s2 = l_reg.flg_s1;
        ack_edge = l_reg.ack_s2 ^ l_reg.ack_prev;
        if (ack_edge) begin
            l_next.hc = 1'b0;
        end
        // Accept a core word; push data held stable by the toggle
        if ((l_reg.push_s2 != l_reg.push_seen) && !l_reg.rx_full) begin
            l_next.rx_data = s_reg.push_data;
            l_next.rx_full = 1'b1;
            l_next.push_seen = l_reg.push_s2;
        end
        // Address decode
        is_pci = (cfg_i.mode == MODE_PCI);
        is_ub = cfg_i.mode[1];
        ub16 = (cfg_i.rx_fmt != 2'h0);
        ub16_cmd = ub16 || (cfg_i.tx_fmt != 2'h0);
        sel_cmd = is_pci ? (acc_i.addr == OFS_CMD_VECTOR)
            : (is_ub && acc_i.addr[10:3] == cfg_i.base
               && acc_i.addr[2:0] == UB_SEL_CMD);
        sel_rx = !acc_i.write && (is_pci
            ? (acc_i.addr >= OFS_RX_FIRST && acc_i.addr <= OFS_RX_LAST)
            : (is_ub && acc_i.addr[10:3] == cfg_i.base
               && acc_i.addr[2:0] == UB_SEL_RX));
        sel_st = !acc_i.write && (is_pci ? (acc_i.addr == OFS_STATUS)
            : (is_ub && acc_i.addr[10:3] == cfg_i.base
               && acc_i.addr[2:0] == UB_SEL_STATUS));
        blocked = (sel_cmd && acc_i.write && l_reg.hc)
            || (sel_rx && !l_reg.rx_full);
        go = 1'b0;
        // UB writes zero-fill above the bus width
        wd = acc_i.wdata;
        if (is_ub) begin
            wd = ub16_cmd ? {16'h0000, acc_i.wdata[15:0]}
                : {8'h00, acc_i.wdata[23:0]};
        end
        // Access sequencer
        case (l_reg.fsm)
            ST_IDLE: begin
                if (acc_req_i) begin
                    if (!blocked) begin
                        go = 1'b1;
                    end else if (is_pci && cfg_i.target_wait_disable) begin
                        l_next.retry = 1'b1;
                        l_next.fsm = ST_GAP;
                    end else begin
                        l_next.wcnt = 4'h0;
                        l_next.fsm = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (!blocked) begin
                    go = 1'b1;
                end else if (is_pci && l_reg.wcnt == MAX_WAITS - 4'h1) begin
                    l_next.retry = 1'b1;
                    l_next.fsm = ST_GAP;
                end else if (is_pci) begin
                    l_next.wcnt = l_reg.wcnt + 4'h1;
                end
            end
            ST_GAP: begin
                // Host must drop its request before the next one
                if (!acc_req_i) begin
                    l_next.fsm = ST_IDLE;
                end
            end
            default: l_next.fsm = ST_IDLE;
        endcase
        // Perform the access
        if (go) begin
            l_next.done = 1'b1;
            l_next.fsm = ST_GAP;
            l_next.rdata = 32'h0000_0000;
            l_next.kind = K_NONE;
            if (sel_cmd) begin
                l_next.kind = K_CMD;
                if (acc_i.write) begin
                    if (acc_i.be[0]) begin
                        l_next.hc = l_next.hc | wd[CV_PEND_BIT];
                        l_next.hv = wd[CV_VEC_LSB +: 7];
                    end
                    if (acc_i.be[1]) begin
                        l_next.nmi = wd[CV_NMI_BIT];
                    end
                end else begin
                    l_next.rdata[CV_PEND_BIT] = l_reg.hc;
                    l_next.rdata[CV_VEC_LSB +: 7] = l_reg.hv;
                    l_next.rdata[CV_NMI_BIT] = l_reg.nmi;
                end
            end else if (sel_rx) begin
                l_next.kind = K_RX;
                l_next.rdata = fmt_rx(l_reg.rx_data, cfg_i.rx_fmt, is_pci);
                if (is_ub && !ub16) begin
                    l_next.rdata = {8'h00, l_reg.rx_data[23:0]};
                end
                l_next.rx_full = 1'b0;
            end else if (sel_st) begin
                l_next.kind = K_STAT;
                l_next.rdata[ST_TRDY] = tx_ready_i;
                l_next.rdata[ST_TRQ] = tx_space_available_i;
                l_next.rdata[ST_RRQ] = l_reg.rx_full && !cfg_i.fetch_type_select;
                l_next.rdata[ST_FLAG_LSB +: 4] = l_reg.flg_s2;
                l_next.rdata[ST_HOST_REQUEST_FLAG] = l_reg.host_request_flag;
            end
            // UB reads return the low bytes only
            if (is_ub && !sel_rx) begin
                l_next.rdata = ub16_cmd ? {16'h0000, l_next.rdata[15:0]}
                    : {8'h00, l_next.rdata[23:0]};
            end
        end
        // software resets clear the host pending bit and empty the rx stage
        if (pers_sw_reset_i || sw_reset_i) begin
            l_next.hc = 1'b0;
            l_next.rx_full = 1'b0;
        end
        if (pers_hw_reset_i) begin
            l_next.hv = cmd_default_vector_i;
            l_next.nmi = 1'b0;
        end
        l_next.host_request_flag = (l_next.rx_full && !cfg_i.fetch_type_select && cfg_i.rx_request_enable)
            || (tx_space_available_i && cfg_i.tx_request_enable);
        if (pers_hw_reset_i) begin
            l_next.host_request_flag = 1'b0;
        end
        l_next.irq = is_ub && l_next.host_request_flag && !cfg_i.dma_mode_enable;
        l_next.drq = is_ub && l_next.host_request_flag && cfg_i.dma_mode_enable;
    end

    // Link domain registers
    always_ff @(posedge clk_link_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            l_reg <= '0;
            l_reg.fsm <= ST_IDLE;
            l_reg.kind <= K_NONE;
            l_reg.hv <= RST_VECTOR;
        end else begin
            l_reg <= l_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // System domain next state
    always_comb begin
        s_next = s_reg;
        s_next.hc_s1 = l_reg.hc;
        s_next.hc_s2 = s_reg.hc_s1;
        s_next.seen_s1 = l_reg.push_seen;
        s_next.seen_s2 = s_reg.seen_s1;
        // Ack wait stops a stale synced bit from re-raising pending
        if (!s_reg.hc_s2) begin
            s_next.ack_wait = 1'b0;
        end
        // vector and select stable while pending
        if (s_reg.hc_s2 && !s_reg.pend && !s_reg.ack_wait) begin
            s_next.pend = 1'b1;
            s_next.vec = l_reg.hv;
            s_next.nmi = l_reg.nmi;
        end
        if (cmd_ack_i && s_reg.pend) begin
            s_next.pend = 1'b0;
            s_next.ack_wait = 1'b1;
            s_next.ack_tgl = !s_reg.ack_tgl;
        end
        // Core word push; one word in flight, no queue
        if (s_reg.busy && s_reg.seen_s2 == s_reg.push_tgl) begin
            s_next.busy = 1'b0;
        end
        if (core_rx_valid_i && s_reg.rdy) begin
            s_next.push_data = core_rx_data_i;
            s_next.push_tgl = !s_reg.push_tgl;
            s_next.busy = 1'b1;
        end
        s_next.rdy = !s_next.busy;
        s_next.irq = s_next.pend && (s_next.nmi || command_irq_enable_i);
        s_next.level = s_next.nmi ? NMI_LEVEL
            : {1'b0, peripheral_priority_i};
    end

    // System domain registers
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_reg <= '0;
            s_reg.vec <= RST_VECTOR;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign acc_done_o = l_reg.done;
    assign acc_retry_o = l_reg.retry;
    assign acc_rdata_o = l_reg.rdata;
    assign host_request_flag_o = l_reg.host_request_flag;
    assign host_irq_pin_o = l_reg.irq;
    assign host_dma_request_pin_o = l_reg.drq;
    assign core_rx_ready_o = s_reg.rdy;
    assign core_command_pending_o = s_reg.pend;
    assign cmd_vector_o = s_reg.vec;
    assign cmd_nmi_o = s_reg.nmi;
    assign cmd_start_addr_o = {s_reg.vec, 1'b0};
    assign cmd_irq_o = s_reg.irq;
    assign cmd_level_o = s_reg.level;

    ////////////////////////////////////////////////////////////////////
    // Assertions, link domain
    property p_host_request_flag_rx;
        @(posedge clk_link_i) disable iff (!reset_n_i)
        (l_reg.rx_full && !cfg_i.fetch_type_select && cfg_i.rx_request_enable && !pers_hw_reset_i
         && $stable(cfg_i) && !pers_sw_reset_i && !sw_reset_i && !go)
        |=> host_request_flag_o;
    endproperty
    a_host_request_flag_rx: assert property (p_host_request_flag_rx)
        else $error("request flag missing with rx data");

    property p_status_zero;
        @(posedge clk_link_i) disable iff (!reset_n_i)
        (acc_done_o && l_reg.kind == K_STAT) |-> acc_rdata_o[31:8] == 24'h0;
    endproperty
    a_status_zero: assert property (p_status_zero)
        else $error("status upper bits not zero");

    property p_cmd_rsvd;
        @(posedge clk_link_i) disable iff (!reset_n_i)
        (acc_done_o && l_reg.kind == K_CMD)
        |-> (acc_rdata_o[31:16] == 16'h0 && acc_rdata_o[14:8] == 7'h0);
    endproperty
    a_cmd_rsvd: assert property (p_cmd_rsvd)
        else $error("command reserved bits not zero");

    property p_wait_bound;
        @(posedge clk_link_i) disable iff (!reset_n_i)
        (l_reg.fsm == ST_WAIT && is_pci && !cfg_i.target_wait_disable && $stable(cfg_i))
        |-> ##[1:8] (l_reg.fsm != ST_WAIT);
    endproperty
    a_wait_bound: assert property (p_wait_bound)
        else $error("too many PCI wait states");

    property p_no_wait;
        @(posedge clk_link_i) disable iff (!reset_n_i)
        (l_reg.fsm == ST_IDLE && acc_req_i && blocked && is_pci
         && cfg_i.target_wait_disable) |=> (acc_retry_o && l_reg.fsm == ST_GAP);
    endproperty
    a_no_wait: assert property (p_no_wait)
        else $error("no immediate disconnect");

    property p_hc_hold;
        @(posedge clk_link_i) disable iff (!reset_n_i)
        $fell(l_reg.hc) |-> $past(ack_edge || pers_sw_reset_i || sw_reset_i);
    endproperty
    a_hc_hold: assert property (p_hc_hold)
        else $error("pending bit cleared without ack");

    property p_rx_empty;
        @(posedge clk_link_i) disable iff (!reset_n_i)
        (acc_done_o && l_reg.kind == K_RX) |-> !l_reg.rx_full;
    endproperty
    a_rx_empty: assert property (p_rx_empty)
        else $error("rx stage not emptied by read");

    property p_fetch_zero;
        @(posedge clk_link_i) disable iff (!reset_n_i)
        (acc_done_o && l_reg.kind == K_STAT && $past(cfg_i.fetch_type_select))
        |-> !acc_rdata_o[ST_RRQ];
    endproperty
    a_fetch_zero: assert property (p_fetch_zero)
        else $error("rx flag shown in fetch mode");

    property p_irq_pin;
        @(posedge clk_link_i) disable iff (!reset_n_i)
        host_irq_pin_o |-> (host_request_flag_o && !host_dma_request_pin_o);
    endproperty
    a_irq_pin: assert property (p_irq_pin)
        else $error("irq pin without request flag");

    // Assertions, system domain, then covers of both domains
    property p_nmi_top;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (s_reg.pend && s_reg.nmi) |=> (cmd_irq_o && cmd_level_o == NMI_LEVEL)
            or (!s_reg.pend);
    endproperty
    a_nmi_top: assert property (p_nmi_top)
        else $error("nonmaskable command not top level");

    property p_ack_clear;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (cmd_ack_i && core_command_pending_o) |=> !core_command_pending_o;
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("ack did not clear pending");

    c_retry: cover property (@(posedge clk_link_i) acc_retry_o);
    c_rx_read: cover property (@(posedge clk_link_i)
        acc_done_o && l_reg.kind == K_RX);
    c_cmd_irq: cover property (@(posedge clk_sys_i) cmd_irq_o);

endmodule
`default_nettype wire

//--- sim/hcsr_core_model.sv
// Core-side partner: pushes receive words and acknowledges commands
`timescale 1ns/1ps
`default_nettype none
module hcsr_core_model (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Bench control
    input wire logic push_i,
    input wire logic [31:0] push_data_i,
    input wire logic ack_en_i,
    // Port side
    input wire logic core_rx_ready_i,
    input wire logic core_command_pending_i,
    output logic core_rx_valid_o,
    output logic [31:0] core_rx_data_o,
    output logic cmd_ack_o
);
    ////////////////////////////////////////////////////////////////////////
    // Word held until taken; idle data flips so stale values never match
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_rx_valid_o <= 1'b0;
            core_rx_data_o <= 32'h0;
        end else if (core_rx_valid_o && core_rx_ready_i) begin
            core_rx_valid_o <= 1'b0;
            core_rx_data_o <= ~core_rx_data_o;
        end else if (!core_rx_valid_o && push_i) begin
            core_rx_valid_o <= 1'b1;
            core_rx_data_o <= push_data_i;
        end else if (!core_rx_valid_o) begin
            core_rx_data_o <= ~core_rx_data_o;
        end
    end
    // core acknowledge pulse
    // Holding ack_en low models a core that is slow to serve
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_ack_o <= 1'b0;
        end else begin
            cmd_ack_o <= core_command_pending_i && ack_en_i && !cmd_ack_o;
        end
    end
endmodule
`default_nettype wire

//--- sim/hcsr_host_port_test.sv
// Self-checking bench of the host command and slave receive port
`timescale 1ns/1ps
`default_nettype none
module hcsr_host_port_test;
    import hcsr_pkg::*;
    logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, req = 1'b0;
    logic phw = 1'b0, swr = 1'b0, txs = 1'b1, ack_en = 1'b0, push = 1'b0;
    logic irqen = 1'b0, done, retry, rx_format_select, irq, drq, valid, ack, ready;
    logic pend, nmi, cirq, rt, psw = 1'b0;
    logic [31:0] pd = 32'h0, rdata, rxd, rd;
    logic [7:0] sa;
    logic [6:0] vec;
    logic [2:0] lvl;
    hcsr_acc_t acc = '0;
    hcsr_cfg_t cfg = '0;
    int num_errors = 0, num_checks = 0, n, n0, cyc = 0;
    always #20 clk = ~clk;
    always #7.5 lclk = ~lclk;
    hcsr_host_port dut (.clk_sys_i(clk), .reset_n_i(rst_n),
        .clk_link_i(lclk), .acc_req_i(req), .acc_i(acc), .cfg_i(cfg),
        .pers_hw_reset_i(phw), .pers_sw_reset_i(psw), .sw_reset_i(swr),
        .tx_space_available_i(txs), .tx_ready_i(1'b0),
        .cmd_default_vector_i(7'h11), .acc_done_o(done),
        .acc_retry_o(retry), .acc_rdata_o(rdata),
        .host_request_flag_o(rx_format_select), .host_irq_pin_o(irq),
        .host_dma_request_pin_o(drq), .core_flags_i(4'h5),
        .cmd_ack_i(ack), .command_irq_enable_i(irqen),
        .peripheral_priority_i(2'h2), .core_rx_valid_i(valid),
        .core_rx_data_i(rxd), .core_rx_ready_o(ready),
        .core_command_pending_o(pend), .cmd_vector_o(vec),
        .cmd_nmi_o(nmi), .cmd_start_addr_o(sa), .cmd_irq_o(cirq),
        .cmd_level_o(lvl));
    hcsr_core_model core (.clk_sys_i(clk), .reset_n_i(rst_n),
        .push_i(push), .push_data_i(pd), .ack_en_i(ack_en),
        .core_rx_ready_i(ready), .core_command_pending_i(pend),
        .core_rx_valid_o(valid), .core_rx_data_o(rxd), .cmd_ack_o(ack));
    ////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        num_checks++;
        if (seen !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h seen %h", nm, e, seen);
        end
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Request held until done or retry, then dropped for one cycle
    task xfer(input logic w, input logic [15:0] a, input logic [3:0] be,
              input logic [31:0] d);
        @(negedge lclk);
        req = 1'b1;
        acc = '{write: w, addr: a, be: be, wdata: d};
        n = 0;
        do begin
            @(negedge lclk);
            n++;
        end while (!(done || retry) && n < 100);
        rd = rdata;
        rt = retry;
        req = 1'b0;
        @(negedge lclk);
    endtask
    task rdc(input logic [15:0] a, input logic [31:0] e);
        xfer(1'b0, a, 4'h0, 32'h0);
        chk("rdata", rd, e);
    endtask
    task wt(input logic e);
        for (int i = 0; i < 60 && rx_format_select !== e; i++) @(negedge lclk);
        chk("flag", rx_format_select, e);
    endtask
    task wpend(input logic e);
        for (int i = 0; i < 40 && pend !== e; i++) @(negedge clk);
        chk("pend", pend, e);
    endtask
    task pushw(input logic [31:0] d);
        @(negedge clk);
        push = 1'b1;
        pd = d;
        @(negedge clk);
        push = 1'b0;
    endtask
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        cfg.mode = MODE_PCI;
        cfg.rx_fmt = 2'h3;
        cfg.rx_request_enable = 1'b1;
        cfg.tx_request_enable = 1'b1;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge lclk);
        rdc(OFS_STATUS, 32'h0000_00AA);
        cfg.tx_request_enable = 1'b0;
        wt(1'b0);
        // reserved bits zero, NMI bit written only through byte enable 1
        xfer(1'b1, OFS_CMD_VECTOR, 4'hF, 32'h0000_800A);
        rdc(OFS_CMD_VECTOR, 32'h0000_800A);
        xfer(1'b1, OFS_CMD_VECTOR, 4'h2, 32'h0000_0000);
        rdc(OFS_CMD_VECTOR, 32'h0000_000A);
        xfer(1'b1, OFS_CMD_VECTOR, 4'h1, 32'h0000_0007);
        wpend(1'b1);
        chk("start", sa, 32'h06);
        chk("irq", cirq, 32'h0);
        irqen = 1'b1;
        repeat (2) @(negedge clk);
        chk("irq", cirq, 32'h1);
        chk("lvl", lvl, 32'h2);
        xfer(1'b1, OFS_CMD_VECTOR, 4'hF, 32'h0000_0006);
        n0 = n;
        chk("retry", rt, 32'h1);
        cfg.target_wait_disable = 1'b1;
        xfer(1'b1, OFS_CMD_VECTOR, 4'hF, 32'h0000_0006);
        chk("retry", rt, 32'h1);
        chk("waits", n0 - n, 32'h8);
        ack_en = 1'b1;
        wpend(1'b0);
        // Host bit clears a few link edges after the core ack
        repeat (5) @(negedge lclk);
        rdc(OFS_CMD_VECTOR, 32'h0000_0006);
        cfg.target_wait_disable = 1'b0;
        xfer(1'b0, OFS_RX_FIRST, 4'h0, 32'h0);
        chk("retry", rt, 32'h1);
        pushw(32'h1234_5678);
        wt(1'b1);
        rdc(OFS_RX_FIRST, 32'h1234_5678);
        wt(1'b0);
        pushw(32'hA5A5_0F0F);
        wt(1'b1);
        rdc(OFS_RX_LAST, 32'hA5A5_0F0F);
        cfg.mode = 2'h2;
        cfg.rx_fmt = 2'h0;
        pushw(32'hCAFE_1234);
        wt(1'b1);
        chk("pins", {irq, drq}, 32'h2);
        rdc(16'h0007, 32'h00FE_1234);
        xfer(1'b1, 16'h0006, 4'hF, 32'hFF00_8010);
        rdc(16'h0006, 32'h0000_8010);
        irqen = 1'b0;
        ack_en = 1'b0;
        xfer(1'b1, 16'h0006, 4'hF, 32'h0000_8011);
        wpend(1'b1);
        chk("irq", cirq, 32'h1);
        chk("lvl", lvl, 32'h4);
        chk("vec", vec, 32'h08);
        chk("nmi", nmi, 32'h1);
        ack_en = 1'b1;
        xfer(1'b1, 16'h0006, 4'hF, 32'h0000_8012);
        chk("retry", rt, 32'h0);
        chk("waits", n > 3, 32'h1);
        wpend(1'b0);
        ack_en = 1'b0;
        xfer(1'b1, 16'h0006, 4'hF, 32'h0000_0013);
        wpend(1'b1);
        @(negedge lclk) psw = 1'b1;
        @(negedge lclk) psw = 1'b0;
        rdc(16'h0006, 32'h0000_0012);
        ack_en = 1'b1;
        wpend(1'b0);
        cfg.dma_mode_enable = 1'b1;
        pushw(32'h0000_0001);
        wt(1'b1);
        chk("pins", {irq, drq}, 32'h1);
        @(negedge lclk) swr = 1'b1;
        @(negedge lclk) swr = 1'b0;
        wt(1'b0);
        @(negedge lclk) phw = 1'b1;
        @(negedge lclk) phw = 1'b0;
        rdc(16'h0006, 32'h0000_0022);
        cfg.fetch_type_select = 1'b1;
        pushw(32'h0000_0002);
        repeat (30) @(negedge lclk);
        chk("flag", rx_format_select, 32'h0);
        rdc(16'h0005, 32'h0000_002A);
        cfg.fetch_type_select = 1'b0;
        wt(1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire
